// >>> dv/ssc_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// far-side serial device: logs bits, feeds data, makes the clock if asked
module ssc_partner (
  input wire logic clk,
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic ext_sck
);
  logic [15:0] got = 16'h0000;
  int nb = 0;
  logic [7:0] feed = 8'h00;
  initial begin
    sdi = 1'b1;
    ext_sck = 1'b1; // idle high, doubles as the pin pull-up
  end
  // capture on the rising edge, where the device samples too
  always @(posedge sck) begin
    got <= {got[14:0], sdo};
    nb <= nb + 1;
  end
  // new bit after each fall so it is settled by the rise
  always @(negedge sck) begin
    sdi <= feed[7];
    feed <= {feed[6:0], ~feed[7]}; // keeps toggling past the byte
  end
  // five system clocks per level, on clock edges; a caller may pulse past the byte count
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_sck <= 1'b0;
      repeat (5) @(posedge clk);
      ext_sck <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // ssc_partner

// >>> dv/sync_serial_tx_rx_core_tb_top.sv
`timescale 1ns/1ps
module sync_serial_tx_rx_core_tb_top;
  import ssc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sck_out, sck_oe_n, sdi, sdo, irq, ext_sck;
  wire logic sck;
  int err_total = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  int irq_nb = 0;
  logic [7:0] rv;

  always #4 clk = ~clk;
  // released pin falls back to the far side, which rests high
  assign sck = sck_oe_n ? ext_sck : sck_out;

  ssc_core dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe_n(sck_oe_n), .serial_in_pin(sdi), .serial_out_pin(sdo),
    .transfer_done_irq(irq));
  ssc_partner pu (.clk(clk), .sck(sck), .sdo(sdo), .sdi(sdi), .ext_sck(ext_sck));

  // irq pulses, with the partner's bit count when each fires
  always @(posedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt++;
      irq_nb = pu.nb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7 - i];
    end
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_irq(input int k);
    int n;
    n = 0;
    while (irq_cnt < k && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(16'(irq_cnt >= k), 16'h0001, "irq seen");
  endtask
  // poll running low before any restart, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    rv = 8'hff;
    while (rv[SSC_STAT_RUN_BIT] !== 1'b0 && n < 100) begin
      rd(SSC_ADDR_STATUS, rv);
      n++;
    end
    chk(16'(rv[SSC_STAT_RUN_BIT]), 16'h0000, "stopped");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_tx(input logic [7:0] ctl, input int nby, input logic [15:0] w,
      input logic [15:0] exp);
    int nb0, k;
    k = irq_cnt;
    wr(SSC_ADDR_CTRL_ONE, ctl);
    wr(SSC_ADDR_CTRL_TWO, 8'(nby - 1));
    if (nby == 2) wr(SSC_ADDR_BUFFER, w[15:8]);
    wr(SSC_ADDR_BUFFER, w[7:0]);
    nb0 = pu.nb;
    wr(SSC_ADDR_CTRL_ONE, ctl | 8'h80);
    wait_irq(k + 1);
    wr(SSC_ADDR_CTRL_ONE, ctl);
    wait_idle();
    chk(16'(pu.nb - nb0), 16'(8 * nby), "bits sent");
    chk(16'(irq_nb - nb0), 16'(8 * nby - 7), "irq point");
    chk(nby == 2 ? pu.got : {8'h00, pu.got[7:0]}, exp, "tx data");
    chk(16'({rv[7], rv[5], rv[3]}), 16'h0002, "status");
    chk(16'({sck, sdo}), 16'h0003, "idle pins");
  endtask
  task automatic t_rx();
    int k;
    k = irq_cnt;
    pu.feed = 8'hc5;
    wr(SSC_ADDR_CTRL_ONE, 8'h1e);
    wr(SSC_ADDR_CTRL_TWO, 8'h00);
    wr(SSC_ADDR_CTRL_ONE, 8'h9e);
    wait_irq(k + 1);
    rd(SSC_ADDR_STATUS, rv);
    chk(16'(rv[SSC_STAT_RXF_BIT]), 16'h0001, "rx full");
    rd(SSC_ADDR_BUFFER, rv);
    chk({8'h00, rv}, {8'h00, rev8(8'hc5)}, "rx byte");
    wr(SSC_ADDR_CTRL_ONE, 8'h1e);
    wait_idle();
  endtask
  task automatic t_txrx();
    int k;
    k = irq_cnt;
    pu.feed = 8'h96;
    wr(SSC_ADDR_CTRL_ONE, 8'h26);
    wr(SSC_ADDR_CTRL_TWO, 8'h00);
    wr(SSC_ADDR_BUFFER, 8'h69);
    wr(SSC_ADDR_CTRL_ONE, 8'ha6);
    wait_irq(k + 1);
    chk({8'h00, pu.got[7:0]}, 16'h0069, "duplex sent");
    rd(SSC_ADDR_BUFFER, rv);
    chk({8'h00, rv}, 16'h0096, "duplex received");
    wr(SSC_ADDR_CTRL_ONE, 8'h26);
    wait_idle();
  endtask
  task automatic t_halt();
    int nb0;
    wr(SSC_ADDR_CTRL_ONE, 8'h06);
    wr(SSC_ADDR_CTRL_TWO, 8'h00);
    wr(SSC_ADDR_BUFFER, 8'h5a);
    wr(SSC_ADDR_CTRL_ONE, 8'h86);
    repeat (12) @(posedge clk);
    wr(SSC_ADDR_CTRL_ONE, 8'h46);
    nb0 = pu.nb;
    repeat (40) @(posedge clk);
    rd(SSC_ADDR_STATUS, rv);
    chk(16'({rv[7], rv[3], pu.nb != nb0}), 16'h0000, "halt mid byte");
  endtask
  task automatic t_err();
    wr(SSC_ADDR_CTRL_ONE, 8'h07);
    wr(SSC_ADDR_CTRL_TWO, 8'h00);
    wr(SSC_ADDR_BUFFER, 8'h81);
    wr(SSC_ADDR_CTRL_ONE, 8'h87);
    #2;
    chk(16'(sck_oe_n), 16'h0001, "pin released");
    pu.pulse(8);
    chk({8'h00, pu.got[7:0]}, 16'h0081, "ext byte");
    pu.pulse(1); // one fall too many, on purpose
    repeat (4) @(posedge clk);
    rd(SSC_ADDR_STATUS, rv);
    chk(16'({rv[7], rv[3], sdo}), 16'h0007, "tx error");
    wr(SSC_ADDR_CTRL_ONE, 8'h47);
    rd(SSC_ADDR_STATUS, rv);
    chk(16'({rv[7], rv[4], rv[3]}), 16'h0000, "status init");
    rd(SSC_ADDR_CTRL_ONE, rv);
    chk({8'h00, rv}, 16'h0007, "ctrl kept");
    rd(8'h20, rv);
    chk({8'h00, rv}, 16'h0000, "unmapped");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // the whole run needs about 3.2 us
  initial begin
    #100us;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk);
    chk(16'({sck_out, sck_oe_n, sdo, irq, reg_rdata}), 16'h0a00, "reset");
    sys_rst <= 1'b0;
    t_tx(8'h06, 2, 16'ha53c, 16'ha53c);
    $display("tx msb first done");
    t_tx(8'h0e, 1, 16'h001e, {8'h00, rev8(8'h1e)});
    $display("tx lsb first done");
    t_rx();
    $display("rx done");
    t_txrx();
    $display("duplex done");
    t_halt();
    $display("halt done");
    t_err();
    $display("tx error done");
    end_sim();
  end
endmodule // sync_serial_tx_rx_core_tb_top

// >>> rtl/ssc_clk_div.sv
`timescale 1ns/1ps
module ssc_clk_div (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic tick
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
  } ssc_div_type;

  ssc_div_type div_ff;
  ssc_div_type nxt_div;
  logic [11:0] lim;

  ////////////////////////////////////////////////////////////////////////////
  // half-period limit per rate code; tick toggles the bit clock
  always_comb begin
    case (rate_sel)
      3'h0: lim = SSC_HALF_R0;
      3'h1: lim = SSC_HALF_R1;
      3'h2: lim = SSC_HALF_R2;
      3'h3: lim = SSC_HALF_R3;
      3'h4: lim = SSC_HALF_R4;
      3'h5: lim = SSC_HALF_R5;
      default: lim = SSC_HALF_R6;
    endcase
    nxt_div = div_ff;
    if (!run) begin
      nxt_div.cnt = '0;
    end else if (div_ff.cnt == lim) begin
      nxt_div.cnt = '0;
    end else begin
      nxt_div.cnt = div_ff.cnt + 12'h0001;
    end
  end

  assign tick = run && (div_ff.cnt == lim);

  // counter register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

endmodule // ssc_clk_div

// >>> rtl/ssc_core.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - received bits are sampled on the rising edge of the serial clock pin.
// - one order bit sets bit order for both sending and receiving.
// - order bit 0 sends msb first and stores the first received bit as msb.
// - order bit 1 sends lsb first and stores the first received bit as lsb.
// - mode 00 is transmit only, mode 01 is receive only.
// - byte_count holds the number of bytes minus one.
// - start sends at once on internal clock, else with each external pulse.
// - transmit interrupt fires when the second bit of the last byte starts.
// - start cleared in the final byte finishes that byte, then running drops.
// - writing 1 to force_halt stops a transmission at once, even mid byte.
// - external falling edge with running and empty buffer sets error, output high.
// - force_halt clears start, the whole status register and the buffer pointers, not the other control fields.
// - running is status bit 7, transmit error is status bit 3.
// - receive starts at once on internal clock, else with each external pulse.
// - transmit bits shift out on the falling edge of the serial clock pin.
// - rate codes 000 to 110 divide the system clock, 111 selects the pin.
// - internal clock keeps the serial clock pin high at start and end.
// - mode 10 sends and receives bytes at the same time.
module ssc_core #(
  parameter int PTR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic transfer_done_irq
);
  import ssc_pkg::*;

  typedef struct packed {
    logic start;
    logic lsb_first;
    logic [1:0] mode;
    logic [2:0] rate;
    logic [7:0] count;
    logic running;
    logic tx_err;
    logic tx_empty;
    logic rx_full;
    ssc_phase_type phase;
    logic [2:0] bit_cnt;
    logic [PTR_W:0] started;
    logic [PTR_W:0] done;
    logic [PTR_W:0] wr_num;
    logic [PTR_W:0] rd_num;
    logic sck;
    logic sck_prev;
    logic irq;
    logic [7:0] rdata;
  } ssc_core_type;

  ssc_core_type st_ff;
  ssc_core_type nxt_st;
  logic [7:0] mem [0:(1<<PTR_W)-1];

  logic ext_clk;
  logic tx_on;
  logic rx_on;
  logic tick;
  logic fall_ev;
  logic rise_ev;
  logic load;
  logic shift;
  logic sample;
  logic halt;
  logic force_high;
  logic mem_we;
  logic [PTR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] rd_byte;
  logic [7:0] rx_nxt;
  logic tx_bit;
  logic [PTR_W:0] total;

  ////////////////////////////////////////////////////////////////////////////
  // decoded mode and clock source
  assign ext_clk = (st_ff.rate == SSC_RATE_EXT);
  assign tx_on = (st_ff.mode == SSC_MODE_TX) || (st_ff.mode == SSC_MODE_TXRX);
  assign rx_on = (st_ff.mode == SSC_MODE_RX) || (st_ff.mode == SSC_MODE_TXRX);
  assign total = {{(PTR_W-7){1'b0}}, st_ff.count} + {{PTR_W{1'b0}}, 1'b1};
  assign rd_byte = mem[st_ff.rd_num[PTR_W-1:0]];

  // serial clock edges from either source; pin input is synchronous
  assign fall_ev = ext_clk ? (st_ff.sck_prev && !serial_clock_pin_in)
                           : (tick && st_ff.sck);
  assign rise_ev = ext_clk ? (!st_ff.sck_prev && serial_clock_pin_in)
                           : (tick && !st_ff.sck);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: register port, burst sequencing, halt
  always_comb begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    nxt_st.sck_prev = serial_clock_pin_in;
    nxt_st.rdata = 8'h00;
    load = 1'b0;
    shift = 1'b0;
    sample = 1'b0;
    halt = 1'b0;
    mem_we = 1'b0;
    mem_wa = st_ff.wr_num[PTR_W-1:0];
    mem_wd = reg_wdata;

    // reads: data only in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        SSC_ADDR_CTRL_ONE: begin
          nxt_st.rdata[SSC_CTRL_START_BIT] = st_ff.start;
          nxt_st.rdata[SSC_CTRL_MODE_HI:SSC_CTRL_MODE_LO] = st_ff.mode;
          nxt_st.rdata[SSC_CTRL_DIR_BIT] = st_ff.lsb_first;
          nxt_st.rdata[SSC_CTRL_RATE_HI:SSC_CTRL_RATE_LO] = st_ff.rate;
        end
        SSC_ADDR_CTRL_TWO: begin
          nxt_st.rdata = st_ff.count;
        end
        SSC_ADDR_STATUS: begin
          nxt_st.rdata[SSC_STAT_RUN_BIT] = st_ff.running;
          nxt_st.rdata[SSC_STAT_TXE_BIT] = st_ff.tx_empty;
          nxt_st.rdata[SSC_STAT_RXF_BIT] = st_ff.rx_full;
          nxt_st.rdata[SSC_STAT_ERR_BIT] = st_ff.tx_err;
        end
        SSC_ADDR_BUFFER: begin
          // received bytes drain in arrival order once the burst is in
          if (rx_on && st_ff.rx_full) begin
            nxt_st.rdata = rd_byte;
            nxt_st.rd_num = st_ff.rd_num + 1'b1;
            if (nxt_st.rd_num == total) begin
              nxt_st.rx_full = 1'b0;
            end
          end
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end

    // writes
    if (reg_wr) begin
      case (reg_addr)
        SSC_ADDR_CTRL_ONE: begin
          nxt_st.start = reg_wdata[SSC_CTRL_START_BIT];
          nxt_st.mode = reg_wdata[SSC_CTRL_MODE_HI:SSC_CTRL_MODE_LO];
          nxt_st.lsb_first = reg_wdata[SSC_CTRL_DIR_BIT];
          nxt_st.rate = reg_wdata[SSC_CTRL_RATE_HI:SSC_CTRL_RATE_LO];
          halt = reg_wdata[SSC_CTRL_HALT_BIT];
        end
        SSC_ADDR_CTRL_TWO: begin
          nxt_st.count = reg_wdata;
        end
        SSC_ADDR_BUFFER: begin
          // transmit data is only accepted while the channel is stopped
          if (!st_ff.running && tx_on && (st_ff.wr_num < total)) begin
            mem_we = 1'b1;
            nxt_st.wr_num = st_ff.wr_num + 1'b1;
            nxt_st.tx_empty = 1'b0;
          end
        end
        default: begin
          nxt_st.rdata = nxt_st.rdata;
        end
      endcase
    end

    // internal clock toggles only inside a burst
    if (tick && !ext_clk) begin
      nxt_st.sck = !st_ff.sck;
    end

    case (st_ff.phase)
      SSC_PH_IDLE: begin
        nxt_st.sck = 1'b1;
        if (st_ff.start) begin
          nxt_st.phase = SSC_PH_RUN;
          nxt_st.running = 1'b1;
          nxt_st.bit_cnt = SSC_BIT_FIRST;
          nxt_st.started = '0;
          nxt_st.done = '0;
          nxt_st.rd_num = '0;
          nxt_st.rx_full = 1'b0;
        end
      end
      SSC_PH_RUN: begin
        if (fall_ev && tx_on) begin
          if (st_ff.bit_cnt == SSC_BIT_FIRST) begin
            if (st_ff.started == total) begin
              nxt_st.tx_err = ext_clk;
            end else begin
              load = 1'b1;
              nxt_st.rd_num = st_ff.rd_num + 1'b1;
              nxt_st.started = st_ff.started + 1'b1;
              if (nxt_st.started == total) begin
                nxt_st.tx_empty = 1'b1;
              end
            end
          end else begin
            shift = 1'b1;
            if ((st_ff.bit_cnt == SSC_BIT_IRQ) && (st_ff.started == total) && !rx_on) begin
              nxt_st.irq = 1'b1;
            end
          end
        end
        if (rise_ev) begin
          sample = 1'b1;
          nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
          if (st_ff.bit_cnt == SSC_BIT_LAST) begin
            nxt_st.done = st_ff.done + 1'b1;
            if (rx_on) begin
              // received byte takes the slot its transmit byte has left
              mem_we = 1'b1;
              mem_wa = st_ff.done[PTR_W-1:0];
              mem_wd = rx_nxt;
            end
            if (nxt_st.done == total) begin
              // last rising edge reached: stop clocking, hold the pin high
              nxt_st.phase = SSC_PH_WAIT;
              nxt_st.rx_full = rx_on;
              nxt_st.rd_num = '0;
              nxt_st.irq = rx_on;
            end
          end
        end
      end
      SSC_PH_WAIT: begin
        // extra external pulses find no data left
        if (fall_ev && tx_on && ext_clk && st_ff.tx_empty) begin
          nxt_st.tx_err = 1'b1;
        end
        if (!st_ff.start) begin
          nxt_st.phase = SSC_PH_IDLE;
          nxt_st.running = 1'b0;
          // rd_num is kept so received bytes can still be read out
          nxt_st.wr_num = '0;
        end
      end
      default: begin
        nxt_st.phase = SSC_PH_IDLE;
      end
    endcase

    // halt is a channel initialise, so it overrides start, the run state, status flags and pointers set above, not the other control fields or buffer writes
    if (halt) begin
      nxt_st.start = 1'b0;
      nxt_st.running = 1'b0;
      nxt_st.tx_err = 1'b0;
      nxt_st.tx_empty = 1'b0;
      nxt_st.rx_full = 1'b0;
      nxt_st.phase = SSC_PH_IDLE;
      nxt_st.bit_cnt = SSC_BIT_FIRST;
      nxt_st.sck = 1'b1;
      nxt_st.irq = 1'b0;
      nxt_st.wr_num = '0;
      nxt_st.rd_num = '0;
      nxt_st.started = '0;
      nxt_st.done = '0;
      load = 1'b0;
      shift = 1'b0;
    end
  end

  // idle high on the data line; error also forces it high
  assign force_high = st_ff.tx_err || (st_ff.phase == SSC_PH_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // bit clock divider and shift engine
  ssc_clk_div u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .run((st_ff.phase == SSC_PH_RUN) && !ext_clk),
    .rate_sel(st_ff.rate),
    .tick(tick)
  );

  ssc_shifter #(.W(8)) u_shift (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load),
    .load_data(rd_byte),
    .shift(shift),
    .sample(sample),
    .lsb_first(st_ff.lsb_first),
    .ser_in(serial_in_pin),
    .force_high(force_high),
    .tx_bit(tx_bit),
    .rx_nxt(rx_nxt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and byte buffer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{phase: SSC_PH_IDLE, sck: 1'b1, sck_prev: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // buffer has no reset; contents are only trusted after being written
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign serial_clock_pin_out = st_ff.sck;
  assign serial_clock_pin_oe_n = ext_clk;
  assign serial_out_pin = tx_bit;
  assign transfer_done_irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_halt_write;
    reg_wr && (reg_addr == SSC_ADDR_CTRL_ONE) && reg_wdata[SSC_CTRL_HALT_BIT];
  endsequence

  sequence s_start_write;
    reg_wr && (reg_addr == SSC_ADDR_CTRL_ONE) && reg_wdata[SSC_CTRL_START_BIT]
      && !reg_wdata[SSC_CTRL_HALT_BIT] && (st_ff.phase == SSC_PH_IDLE);
  endsequence

  property p_halt_clears;
    s_halt_write |=> !st_ff.running && !st_ff.start && !st_ff.tx_err
      && !st_ff.tx_empty && !st_ff.rx_full && !transfer_done_irq;
  endproperty
  a_halt_clears: assert property (p_halt_clears) else $error("halt left state set");

  property p_halt_stops_shift;
    s_halt_write |=> ##1 serial_out_pin && (st_ff.phase == SSC_PH_IDLE);
  endproperty
  a_halt_stops_shift: assert property (p_halt_stops_shift) else $error("halt did not stop");

  property p_status_read;
    reg_rd && (reg_addr == SSC_ADDR_STATUS) |=>
      (reg_rdata[SSC_STAT_RUN_BIT] == $past(st_ff.running))
      && (reg_rdata[SSC_STAT_ERR_BIT] == $past(st_ff.tx_err));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bits misplaced");

  property p_start_runs;
    s_start_write ##1 !halt |=> st_ff.running;
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not run");

  property p_irq_second_bit;
    transfer_done_irq && tx_on && !rx_on
      |-> (st_ff.bit_cnt == SSC_BIT_IRQ) && (st_ff.started == total);
  endproperty
  a_irq_second_bit: assert property (p_irq_second_bit) else $error("irq at wrong bit");

  property p_burst_len;
    (st_ff.phase == SSC_PH_RUN) ##1 (st_ff.phase == SSC_PH_WAIT) |-> st_ff.done == total;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

  property p_run_drop;
    $fell(st_ff.running) |-> $past(st_ff.phase) == SSC_PH_WAIT || $past(halt);
  endproperty
  a_run_drop: assert property (p_run_drop) else $error("running dropped early");

  property p_err_high;
    $rose(st_ff.tx_err) |=> serial_out_pin [*2];
  endproperty
  a_err_high: assert property (p_err_high) else $error("error did not force high");

  property p_msb_first;
    load && !st_ff.lsb_first |=> serial_out_pin == $past(rd_byte[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first");

  property p_lsb_first;
    load && st_ff.lsb_first |=> serial_out_pin == $past(rd_byte[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("lsb not first");

  property p_rx_no_load;
    (st_ff.mode == SSC_MODE_RX) |-> !load && !shift;
  endproperty
  a_rx_no_load: assert property (p_rx_no_load) else $error("receive mode sent data");

  property p_sck_idle;
    !ext_clk && (st_ff.phase != SSC_PH_RUN) |-> serial_clock_pin_out && !serial_clock_pin_oe_n;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock pin not high");

  property p_empty_set;
    load && (nxt_st.started == total) && !halt |=> st_ff.tx_empty;
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty flag missed");

endmodule // ssc_core

// >>> rtl/ssc_pkg.sv
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses on the plain register port
  localparam logic [7:0] SSC_ADDR_CTRL_ONE = 8'h16;
  localparam logic [7:0] SSC_ADDR_CTRL_TWO = 8'h17;
  localparam logic [7:0] SSC_ADDR_STATUS = 8'h18;
  localparam logic [7:0] SSC_ADDR_BUFFER = 8'h19;

  ////////////////////////////////////////////////////////////////////////////
  // serial_control_one fields
  localparam int SSC_CTRL_START_BIT = 7;
  localparam int SSC_CTRL_HALT_BIT = 6;
  localparam int SSC_CTRL_MODE_HI = 5;
  localparam int SSC_CTRL_MODE_LO = 4;
  localparam int SSC_CTRL_DIR_BIT = 3;
  localparam int SSC_CTRL_RATE_HI = 2;
  localparam int SSC_CTRL_RATE_LO = 0;

  // serial_status fields
  localparam int SSC_STAT_RUN_BIT = 7;
  localparam int SSC_STAT_TXE_BIT = 5;
  localparam int SSC_STAT_RXF_BIT = 4;
  localparam int SSC_STAT_ERR_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // transfer modes
  localparam logic [1:0] SSC_MODE_TX = 2'h0;
  localparam logic [1:0] SSC_MODE_RX = 2'h1;
  localparam logic [1:0] SSC_MODE_TXRX = 2'h2;

  // clock rate codes and half-period limits in system clocks (half minus one)
  localparam logic [2:0] SSC_RATE_EXT = 3'h7;
  localparam logic [11:0] SSC_HALF_R0 = 12'h0fff;
  localparam logic [11:0] SSC_HALF_R1 = 12'h007f;
  localparam logic [11:0] SSC_HALF_R2 = 12'h001f;
  localparam logic [11:0] SSC_HALF_R3 = 12'h000f;
  localparam logic [11:0] SSC_HALF_R4 = 12'h0007;
  localparam logic [11:0] SSC_HALF_R5 = 12'h0003;
  localparam logic [11:0] SSC_HALF_R6 = 12'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions inside a byte
  localparam logic [2:0] SSC_BIT_FIRST = 3'h0;
  localparam logic [2:0] SSC_BIT_IRQ = 3'h1;
  localparam logic [2:0] SSC_BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    SSC_PH_IDLE,
    SSC_PH_RUN,
    SSC_PH_WAIT
  } ssc_phase_type;

endpackage

// >>> rtl/ssc_shifter.sv
`timescale 1ns/1ps
module ssc_shifter #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_data,
  input wire logic shift,
  input wire logic sample,
  input wire logic lsb_first,
  input wire logic ser_in,
  input wire logic force_high,
  output logic tx_bit,
  output logic [W-1:0] rx_nxt
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [W-1:0] tx_sr;
    logic [W-1:0] rx_sr;
    logic out;
  } ssc_shift_type;

  ssc_shift_type sh_ff;
  ssc_shift_type nxt_sh;

  ////////////////////////////////////////////////////////////////////////////
  // one order bit serves both directions
  always_comb begin
    nxt_sh = sh_ff;
    // first received bit ends up at lsb or msb after a full byte
    rx_nxt = lsb_first ? {ser_in, sh_ff.rx_sr[W-1:1]} : {sh_ff.rx_sr[W-2:0], ser_in};
    if (sample) begin
      nxt_sh.rx_sr = rx_nxt;
    end
    if (force_high) begin
      nxt_sh.out = 1'b1;
    end else if (load) begin
      if (lsb_first) begin
        nxt_sh.out = load_data[0];
        nxt_sh.tx_sr = {1'b0, load_data[W-1:1]};
      end else begin
        nxt_sh.out = load_data[W-1];
        nxt_sh.tx_sr = {load_data[W-2:0], 1'b0};
      end
    end else if (shift) begin
      // next bit leaves on a falling edge
      if (lsb_first) begin
        nxt_sh.out = sh_ff.tx_sr[0];
        nxt_sh.tx_sr = {1'b0, sh_ff.tx_sr[W-1:1]};
      end else begin
        nxt_sh.out = sh_ff.tx_sr[W-1];
        nxt_sh.tx_sr = {sh_ff.tx_sr[W-2:0], 1'b0};
      end
    end
  end

  assign tx_bit = sh_ff.out;

  // idle line sits high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_ff <= '{tx_sr: '0, rx_sr: '0, out: 1'b1};
    end else begin
      sh_ff <= nxt_sh;
    end
  end

endmodule // ssc_shifter
